// ### src/wet_pkg.sv
/*
  Shared constants and types for the supervision timer with early warning.
  Assumes a 32-bit APB slave; registers sit at byte address four times their index.
*/
package wet_pkg;

  // Register indices; byte address is the index times four
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_CFG = 6'h01;
  localparam logic [5:0] IDX_EARLY_WARN_CONTROL = 6'h02;
  localparam logic [5:0] IDX_IENCLR = 6'h04;
  localparam logic [5:0] IDX_IENSET = 6'h05;
  localparam logic [5:0] IDX_FLAG = 6'h06;
  localparam logic [5:0] IDX_COUNT = 6'h07;
  localparam logic [5:0] IDX_RESTART = 6'h08;

  // Field positions
  localparam int unsigned CTRL_EN_BIT = 1;
  localparam int unsigned CTRL_WIN_BIT = 2;
  localparam int unsigned EW_BIT = 0;

  // Reset values and keys
  localparam logic [7:0] CFG_RESET = 8'hBB;
  localparam logic [7:0] RESTART_KEY = 8'hA5;
  localparam logic [3:0] CODE_MAX = 4'hB;
  localparam logic [15:0] CODE_BASE = 16'h0008;

  // Supervision clock enable: one tick every TICK_DIV pclk cycles (20 MHz / 20 = 1 MHz)
  localparam logic [15:0] TICK_DIV = 16'h0014;

  typedef struct packed {
    logic window;
    logic enable;
  } wet_ctrl_type;

  typedef struct packed {
    logic [3:0] window_code;
    logic [3:0] period_code;
  } wet_cfg_type;

endpackage

// ### src/wet_supervision_timer.sv
/*
  Supervision timer with early-warning interrupt, normal and windowed modes, APB register slave.
  Assumes synchronous inputs on pclk; the access guard and debugger flags are driven by the system.
*/
// Added by the designer: register access over APB.
// What this block does
// [R1] Enabled timer counts toward period; missing restart raises system reset.
// [R2] Normal and windowed modes, both with optional early warning.
// [R3] Behaviour chosen by control register and interrupt enable state.
// [R4] Early warning after 8<<code ticks; codes 0xC-0xF reserved.
// [R5] Early-warning offset loaded from non-volatile configuration at start-up.
// [R6] Writing one to enable-clear bit 0 clears enable; zero no effect.
// [R7] Set and clear registers share one enable, readable through both.
// [R8] Counting and time-out suspended while processor halted in debug.
// [R9] Writable registers except flag register honour external write protection.
// [R10] Debugger accesses bypass write protection.
// [R11] Interrupt request drives a line to the interrupt controller.
// [R12] Early warning reaches interrupt line only while its enable is set.
`timescale 1ns/1ps
module wet_supervision_timer #(
  parameter logic [15:0] TICK_DIV = wet_pkg::TICK_DIV
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System side
  input wire logic guard_wr_protect,
  input wire logic dbg_access,
  input wire logic dbg_halt,
  input wire logic [3:0] nvm_ew_offset,
  // Outputs to reset logic and interrupt controller
  output logic sys_reset_req,
  output logic irq
);

  function automatic logic [15:0] code_cycles(input logic [3:0] code);
    if (code > wet_pkg::CODE_MAX) begin
      code_cycles = 16'h0000;
    end else begin
      code_cycles = 16'(wet_pkg::CODE_BASE << code);
    end
  endfunction

  wet_pkg::wet_ctrl_type ctrl_q;
  wet_pkg::wet_cfg_type cfg_q;
  logic [3:0] ew_q;
  logic loaded_q;
  logic ien_q;
  logic flag_q;
  logic flag_d;
  logic [15:0] cnt_q;
  logic [15:0] div_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic rst_req_q;
  logic irq_q;

  // Bus decode
  wire [5:0] idx = paddr[7:2];
  wire acc = psel & penable & ~pready_q;
  wire commit = psel & penable & pready_q;
  wire mapped = (idx == wet_pkg::IDX_CTRL) | (idx == wet_pkg::IDX_CFG) | (idx == wet_pkg::IDX_EARLY_WARN_CONTROL) |
                (idx == wet_pkg::IDX_IENCLR) | (idx == wet_pkg::IDX_IENSET) | (idx == wet_pkg::IDX_FLAG) |
                (idx == wet_pkg::IDX_COUNT) | (idx == wet_pkg::IDX_RESTART);
  // [R9] Protected registers
  wire guarded = (idx != wet_pkg::IDX_FLAG) & (idx != wet_pkg::IDX_COUNT);
  // [R10] Debugger bypass
  wire blocked = pwrite & guarded & guard_wr_protect & ~dbg_access;
  wire acc_err = ~mapped | blocked;
  wire wr_ok = commit & pwrite & ~pslverr_q;
  wire wr_ctrl = wr_ok & (idx == wet_pkg::IDX_CTRL);
  wire wr_cfg = wr_ok & (idx == wet_pkg::IDX_CFG);
  wire wr_ew = wr_ok & (idx == wet_pkg::IDX_EARLY_WARN_CONTROL);
  // [R6] Clear on written one
  wire ien_clr = wr_ok & (idx == wet_pkg::IDX_IENCLR) & pwdata[wet_pkg::EW_BIT];
  wire ien_set = wr_ok & (idx == wet_pkg::IDX_IENSET) & pwdata[wet_pkg::EW_BIT];
  wire flag_clr = wr_ok & (idx == wet_pkg::IDX_FLAG) & pwdata[wet_pkg::EW_BIT];
  wire wr_restart = wr_ok & (idx == wet_pkg::IDX_RESTART);
  wire key_ok = pwdata[7:0] == wet_pkg::RESTART_KEY;

  // Timer decode
  wire en = ctrl_q.enable;
  wire div_wrap = div_q >= (TICK_DIV - 16'h0001);
  // [R8] Debug halt freezes tick
  wire tick = en & div_wrap & ~dbg_halt;
  wire [15:0] cnt_nx = cnt_q + 16'h0001;
  wire [15:0] period = code_cycles(cfg_q.period_code);
  wire [15:0] win_open = code_cycles(cfg_q.window_code);
  wire [15:0] ew_cyc = code_cycles(ew_q);
  wire restart = en & wr_restart & key_ok;
  // [R1] Period expiry
  wire timeout = tick & ~restart & (cnt_nx >= period);
  // [R2] Early restart in windowed mode, or a wrong key, is a fault
  wire bad_restart = en & wr_restart & (~key_ok | (ctrl_q.window & (cnt_q < win_open)));
  // [R4] Reserved codes never fire
  wire ew_evt = tick & ~restart & (ew_cyc != 16'h0000) & (cnt_nx == ew_cyc);

  // Reads
  wire [31:0] rd_mux =
    (idx == wet_pkg::IDX_CTRL) ? {29'h0000_0000, ctrl_q.window, ctrl_q.enable, 1'b0} :
    (idx == wet_pkg::IDX_CFG) ? {24'h00_0000, cfg_q} :
    (idx == wet_pkg::IDX_EARLY_WARN_CONTROL) ? {28'h000_0000, ew_q} :
    // [R7] One shared enable
    ((idx == wet_pkg::IDX_IENCLR) | (idx == wet_pkg::IDX_IENSET)) ? {31'h0000_0000, ien_q} :
    (idx == wet_pkg::IDX_FLAG) ? {31'h0000_0000, flag_q} :
    (idx == wet_pkg::IDX_COUNT) ? {16'h0000, cnt_q} :
    32'h0000_0000;

  // APB answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc;
      if (acc) begin
        pslverr_q <= acc_err;
        prdata_q <= (pwrite | acc_err) ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // [R3] Control and configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      cfg_q <= wet_pkg::CFG_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.enable <= pwdata[wet_pkg::CTRL_EN_BIT];
        ctrl_q.window <= pwdata[wet_pkg::CTRL_WIN_BIT];
      end
      if (wr_cfg) begin
        cfg_q <= pwdata[7:0];
      end
    end
  end

  // [R5] Offset taken from non-volatile setting after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_q <= 1'b0;
      ew_q <= 4'h0;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      ew_q <= nvm_ew_offset;
    end else if (wr_ew) begin
      ew_q <= pwdata[3:0];
    end
  end

  // [R7] Shared enable behind set and clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q <= 1'b0;
    end else begin
      ien_q <= (ien_q | ien_set) & ~ien_clr;
    end
  end

  // Set wins over a clear in the same cycle
  assign flag_d = (flag_q & ~flag_clr) | ew_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Supervision clock divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
    end else if (!en || div_wrap) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // [R1] Period counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
    end else if (!en || restart) begin
      cnt_q <= 16'h0000;
    end else if (tick) begin
      cnt_q <= cnt_nx;
    end
  end

  // [R1] Reset request holds until the system reset arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_req_q <= 1'b0;
    end else if (timeout || bad_restart) begin
      rst_req_q <= 1'b1;
    end
  end

  // [R12] Interrupt gated by enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= flag_q & ien_q;
    end
  end

  // [R11] Request line to interrupt controller
  assign irq = irq_q;
  assign sys_reset_req = rst_req_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_access;
    psel & penable & ~pready_q;
  endsequence

  sequence s_answer;
    pready_q ##1 !pready_q;
  endsequence

  property p_apb_answer;
    s_access |=> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("APB answer not a one-cycle pready");

  property p_timeout;
    timeout |=> sys_reset_req;
  endproperty
  a_timeout: assert property (p_timeout) else $error("Timeout did not raise reset"); // [R1]

  property p_window;
    (en & wr_restart & key_ok & ctrl_q.window & (cnt_q < win_open)) |=> sys_reset_req;
  endproperty
  a_window: assert property (p_window) else $error("Early restart in window mode not caught"); // [R2]

  property p_ew_flag;
    (tick & ~restart & (ew_q <= wet_pkg::CODE_MAX) & (cnt_nx == (16'h0008 << ew_q))) |=> flag_q;
  endproperty
  a_ew_flag: assert property (p_ew_flag) else $error("Early warning flag not set"); // [R4]

  property p_nvm_load;
    $rose(loaded_q) |-> (ew_q == $past(nvm_ew_offset));
  endproperty
  a_nvm_load: assert property (p_nvm_load) else $error("Offset not taken from nvm at start"); // [R5]

  property p_ien_clear;
    ien_clr |=> !ien_q ##1 !irq;
  endproperty
  a_ien_clear: assert property (p_ien_clear) else $error("Enable clear failed"); // [R6]

  property p_ien_shared;
    (s_access & ~pwrite & (idx == wet_pkg::IDX_IENCLR)) |=> (prdata[0] == $past(ien_q));
  endproperty
  a_ien_shared: assert property (p_ien_shared) else $error("Clear register does not show enable"); // [R7]

  property p_halt;
    (dbg_halt & ~restart & en) |=> (cnt_q == $past(cnt_q)) & ($past(rst_req_q) | !$rose(sys_reset_req));
  endproperty
  a_halt: assert property (p_halt) else $error("Timer moved during debug halt"); // [R8]

  property p_protect;
    (s_access & pwrite & guard_wr_protect & ~dbg_access & (idx == wet_pkg::IDX_CTRL)) |=> pslverr & pready;
  endproperty
  a_protect: assert property (p_protect) else $error("Protected write not refused"); // [R9]

  property p_dbg_bypass;
    (s_access & pwrite & dbg_access & mapped) |=> !pslverr;
  endproperty
  a_dbg_bypass: assert property (p_dbg_bypass) else $error("Debugger write refused"); // [R10]

  property p_irq;
    (flag_q & ien_q) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt not raised"); // [R11]

  property p_irq_gate;
    !ien_q |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("Interrupt without enable"); // [R12]

endmodule

// ### test/wet_sys_partner.sv
/*
  Model of the system reset logic and interrupt controller facing the supervision timer.
  Assumes one pclk domain; the reset pulse it returns is combined into presetn by the bench.
*/
`timescale 1ns/1ps
module wet_sys_partner (
  // Clock
  input wire logic pclk,
  // From the timer
  input wire logic sys_reset_req,
  input wire logic irq,
  // Back to the system
  output logic sys_rst_n,
  output int rst_count,
  output int irq_count
);
  int hold;
  logic irq_q;
  initial begin
    sys_rst_n = 1'b1;
    rst_count = 0;
    irq_count = 0;
    hold = 0;
    irq_q = 1'b0;
  end
  always @(posedge pclk) begin
    irq_q <= irq;
    if (irq === 1'b1 && irq_q !== 1'b1) begin
      irq_count <= irq_count + 1;
    end
    if (hold > 0) begin
      hold <= hold - 1;
      sys_rst_n <= (hold == 1);
    end else if (sys_reset_req === 1'b1) begin
      hold <= 4;
      sys_rst_n <= 1'b0;
      rst_count <= rst_count + 1;
    end
  end
endmodule

// ### test/wet_supervision_timer_tb.sv
/*
  Register-level bench of the supervision timer over APB, fast tick (TICK_DIV 1).
  Assumes the partner model returns each requested reset as a pulse on presetn.
*/
`timescale 1ns/1ps
module wet_supervision_timer_tb;
  logic pclk, rst_n, psel, penable, pwrite, pready, pslverr, guard, dbg_acc, dbg_halt;
  logic sys_reset_req, irq, sys_rst_n, errv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv, n;
  logic [3:0] nvm;
  int err_count, checks_done, rst_count, irq_count, r0, c, s;
  wire logic presetn = rst_n & sys_rst_n;

  wet_supervision_timer #(.TICK_DIV(16'h0001)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .guard_wr_protect(guard), .dbg_access(dbg_acc), .dbg_halt(dbg_halt),
    .nvm_ew_offset(nvm), .sys_reset_req(sys_reset_req), .irq(irq));
  wet_sys_partner i_sys (.pclk(pclk), .sys_reset_req(sys_reset_req), .irq(irq), .sys_rst_n(sys_rst_n),
    .rst_count(rst_count), .irq_count(irq_count));

  always #25 pclk = ~pclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One APB transfer; waits for pready, then releases and lets an edge pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
    @(posedge pclk);
  endtask

  task automatic wait_rst(input int lim);
    int k;
    r0 = rst_count;
    for (k = 0; k < lim && rst_count == r0; k++) @(posedge pclk);
    check(32'(rst_count - r0), 32'h1);
    for (k = 0; k < 20 && presetn !== 1'b1; k++) @(posedge pclk);
    @(posedge pclk);
  endtask

  initial begin
    pclk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    guard = 0; dbg_acc = 0; dbg_halt = 0; nvm = 4'h2; err_count = 0; checks_done = 0;
    repeat (4) @(posedge pclk);
    rst_n <= 1'b1;
    @(posedge pclk);
    xfer(0, 8'h08, 8'h00); check(rdv, 32'h2);
    xfer(1, 8'h14, 8'h01); xfer(0, 8'h10, 8'h00); check(rdv, 32'h1);
    xfer(1, 8'h10, 8'h00); xfer(0, 8'h14, 8'h00); check(rdv, 32'h1);
    xfer(1, 8'h10, 8'h01); xfer(0, 8'h14, 8'h00); check(rdv, 32'h0);
    $display("done: enable set and clear");
    guard <= 1'b1;
    xfer(1, 8'h14, 8'h01); check(errv, 32'h1);
    xfer(0, 8'h10, 8'h00); check(rdv, 32'h0);
    xfer(1, 8'h18, 8'h01); check(errv, 32'h0);
    xfer(1, 8'h00, 8'h02); check(errv, 32'h1);
    xfer(0, 8'h00, 8'h00); check(rdv, 32'h0);
    dbg_acc <= 1'b1;
    xfer(1, 8'h14, 8'h01); check(errv, 32'h0);
    xfer(1, 8'h10, 8'h01);
    dbg_acc <= 1'b0;
    guard <= 1'b0;
    xfer(0, 8'h0c, 8'h00); check({rdv[30:0], errv}, 32'h1);
    $display("done: protection");
    xfer(1, 8'h04, 8'h0a);
    // First pass uses a reserved code, which must never warn
    for (c = 0; c < 8; c++) begin
      xfer(1, 8'h00, 8'h00);
      xfer(1, 8'h18, 8'h01);
      xfer(1, 8'h08, (c == 0) ? 8'h0c : 8'(c - 1));
      xfer(1, 8'h00, 8'h02);
      for (s = 0; s < 4; s++) begin
        repeat (4 << c) @(posedge pclk);
        dbg_halt <= 1'b1;
        xfer(0, 8'h1c, 8'h00);
        n = rdv;
        repeat (5) @(posedge pclk);
        xfer(0, 8'h1c, 8'h00); check(rdv, n);
        xfer(0, 8'h18, 8'h00); check(rdv & 32'h1, (c > 0 && n >= (32'h4 << c)) ? 32'h1 : 32'h0);
        dbg_halt <= 1'b0;
      end
    end
    check(irq, 32'h0);
    xfer(1, 8'h14, 8'h01);
    repeat (2) @(posedge pclk);
    check({irq, 31'(irq_count)}, 32'h8000_0001);
    xfer(1, 8'h20, 8'ha5);
    xfer(1, 8'h18, 8'h01);
    repeat (2) @(posedge pclk);
    check(irq, 32'h0);
    $display("done: early warning");
    xfer(1, 8'h04, 8'h03);
    r0 = rst_count;
    for (s = 0; s < 5; s++) begin
      repeat (30) @(posedge pclk);
      xfer(1, 8'h20, 8'ha5);
    end
    check(32'(rst_count - r0), 32'h0);
    nvm <= 4'h5;
    wait_rst(200);
    xfer(0, 8'h08, 8'h00); check(rdv, 32'h5);
    $display("done: time-out");
    xfer(1, 8'h04, 8'h45);
    xfer(1, 8'h00, 8'h06);
    repeat (150) @(posedge pclk);
    r0 = rst_count;
    xfer(1, 8'h20, 8'ha5);
    repeat (20) @(posedge pclk);
    check(32'(rst_count - r0), 32'h0);
    xfer(1, 8'h20, 8'ha5);
    wait_rst(50);
    $display("done: window mode");
    tally_and_finish();
  end
endmodule
